// ### shared/bmd_pkg.sv
// Shared constants and types for the banked data memory decoder
package bmd_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int BMD_DATA_W = 8;
   localparam int BMD_ADDR_W = 9;
   localparam int BMD_OFS_W = 7;
   localparam int BMD_AXI_ADDR_W = 8;
   localparam int BMD_AXI_DATA_W = 32;
   localparam int BMD_RAM_DEPTH = 512;

   // ----------------------------------------------------------------
   // Register offsets (index; byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [6:0] BMD_IDX_WINDOW = 7'h00;
   localparam logic [6:0] BMD_IDX_STATUS = 7'h03;
   localparam logic [6:0] BMD_IDX_POINTER = 7'h04;
   localparam logic [6:0] BMD_IDX_INTERRUPT_CONTROL_REGISTER = 7'h0B;

   // ----------------------------------------------------------------
   // Status fields
   // ----------------------------------------------------------------
   localparam int BMD_STATUS_BANK_LSB = 5;
   localparam int BMD_STATUS_IBANK_BIT = 7;

   // ----------------------------------------------------------------
   // Bank layout
   // ----------------------------------------------------------------
   localparam logic [6:0] BMD_GPR_LOW_BASE = 7'h20;
   localparam logic [6:0] BMD_GPR_HIGH_BASE = 7'h10;
   localparam logic [6:0] BMD_SHARED_BASE = 7'h70;
   // Peripheral registers mirrored between bank pairs 0/2 and 1/3
   localparam logic [6:0] BMD_OFS_PAIR_A = 7'h01;
   localparam logic [6:0] BMD_OFS_PAIR_B = 7'h06;
   // Peripheral registers mirrored in all four banks
   localparam logic [6:0] BMD_OFS_ALL_A = 7'h02;
   localparam logic [6:0] BMD_OFS_ALL_B = 7'h0A;

   // ----------------------------------------------------------------
   // Reset values and fixed answers
   // ----------------------------------------------------------------
   localparam logic [7:0] BMD_STATUS_RST = 8'h00;
   localparam logic [7:0] BMD_POINTER_RST = 8'h00;
   localparam logic [7:0] BMD_INTERRUPT_CONTROL_REGISTER_RST = 8'h00;
   localparam logic [7:0] BMD_SELF_READ = 8'h00;
   localparam logic [1:0] BMD_RESP_OKAY = 2'h0;
   localparam logic [1:0] BMD_RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      BMD_K_SELF,
      BMD_K_STATUS,
      BMD_K_POINTER,
      BMD_K_INTERRUPT_CONTROL_REGISTER,
      BMD_K_PERIPH,
      BMD_K_RAM,
      BMD_K_UNIMP,
      BMD_K_BAD
   } bmd_kind_t;

   typedef enum logic [1:0] {
      BMD_SRC_CORE,
      BMD_SRC_AXI_WR,
      BMD_SRC_AXI_RD
   } bmd_src_t;

   typedef enum logic {
      BMD_ST_IDLE,
      BMD_ST_BUSY
   } bmd_state_t;

endpackage

// ### logic/bmd_ram.sv
// Byte-wide static RAM with registered read data
`timescale 1ns/1ps
module bmd_ram
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 512,
   parameter int AW = 9
)
(
   input wire logic aclk,
   input wire logic wr_en,
   input wire logic [AW-1:0] addr,
   input wire logic [WIDTH-1:0] wdata,
   output logic [WIDTH-1:0] rdata
);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [WIDTH-1:0] rdata_reg;

   // Contents carry no reset, as real SRAM
   always_ff @(posedge aclk)
   begin
      if (wr_en)
      begin
         mem_reg[addr] <= wdata;
      end
      rdata_reg <= mem_reg[addr];
   end

   assign rdata = rdata_reg;

endmodule // bmd_ram

// ### logic/bmd_decoder.sv
// Banked data memory decoder with AXI4-Lite register access
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module bmd_decoder
   import bmd_pkg::*;
#(
   parameter int RAM_DEPTH = BMD_RAM_DEPTH
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic core_req,
   input wire logic core_we,
   input wire logic [BMD_OFS_W-1:0] core_offset,
   input wire logic [BMD_DATA_W-1:0] core_wdata,
   output logic core_ready,
   output logic core_ack,
   output logic [BMD_DATA_W-1:0] core_rdata,
   output logic periph_sel,
   output logic periph_we,
   output logic [BMD_ADDR_W-1:0] periph_addr,
   output logic [BMD_DATA_W-1:0] periph_wdata,
   input wire logic [BMD_DATA_W-1:0] periph_rdata,
   output logic [BMD_DATA_W-1:0] machine_status,
   output logic [BMD_DATA_W-1:0] indirect_pointer,
   output logic [BMD_DATA_W-1:0] interrupt_control_register,
   input wire logic [BMD_AXI_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [BMD_AXI_DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [BMD_AXI_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [BMD_AXI_DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // ----------------------------------------------------------------
   // Address decode functions
   // ----------------------------------------------------------------
   function automatic bmd_kind_t decode_kind(
      input logic [BMD_ADDR_W-1:0] a);
      logic [6:0] ofs;
      logic [1:0] bank;
      ofs = a[6:0];
      bank = a[8:7];
      if (ofs == BMD_IDX_WINDOW)
         decode_kind = BMD_K_SELF;
      // one physical copy in every bank
      else if (ofs == BMD_IDX_STATUS)
         decode_kind = BMD_K_STATUS;
      else if (ofs == BMD_IDX_POINTER)
         decode_kind = BMD_K_POINTER;
      else if (ofs == BMD_IDX_INTERRUPT_CONTROL_REGISTER)
         decode_kind = BMD_K_INTERRUPT_CONTROL_REGISTER;
      else if (ofs >= BMD_GPR_LOW_BASE)
         decode_kind = BMD_K_RAM;
      // upper banks hold RAM above few registers
      else if (bank[1] && ofs >= BMD_GPR_HIGH_BASE)
         decode_kind = BMD_K_RAM;
      else if (bank[1] && ofs != BMD_OFS_PAIR_A && ofs != BMD_OFS_PAIR_B
               && ofs != BMD_OFS_ALL_A && ofs != BMD_OFS_ALL_B)
         decode_kind = BMD_K_UNIMP;
      else
         decode_kind = BMD_K_PERIPH;
   endfunction

   // shared top sixteen bytes fold to bank 0
   function automatic logic [BMD_ADDR_W-1:0] ram_index(
      input logic [BMD_ADDR_W-1:0] a);
      if (a[6:0] >= BMD_SHARED_BASE)
         ram_index = {2'b00, a[6:0]};
      else
         ram_index = a;
   endfunction

   // mirrored peripheral registers fold to one address
   function automatic logic [BMD_ADDR_W-1:0] periph_index(
      input logic [BMD_ADDR_W-1:0] a);
      if (a[6:0] == BMD_OFS_ALL_A || a[6:0] == BMD_OFS_ALL_B)
         periph_index = {2'b00, a[6:0]};
      else if (a[8])
         periph_index = {1'b0, a[7], a[6:0]};
      else
         periph_index = a;
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   bmd_state_t state_reg, state_next;
   bmd_src_t src_reg, src_next;
   bmd_kind_t kind_reg, kind_next;
   logic [7:0] status_reg, status_next;
   logic [7:0] pointer_reg, pointer_next;
   logic [7:0] interrupt_control_register_reg, interrupt_control_register_next;
   logic core_ready_reg, core_ready_next;
   logic core_ack_reg, core_ack_next;
   logic [7:0] core_rdata_reg, core_rdata_next;
   logic periph_sel_reg, periph_sel_next;
   logic periph_we_reg, periph_we_next;
   logic [8:0] periph_addr_reg, periph_addr_next;
   logic [7:0] periph_wdata_reg, periph_wdata_next;
   logic aw_have_reg, aw_have_next;
   logic w_have_reg, w_have_next;
   logic ar_have_reg, ar_have_next;
   logic [7:0] aw_addr_reg, aw_addr_next;
   logic [7:0] w_data_reg, w_data_next;
   logic w_lane_reg, w_lane_next;
   logic [7:0] ar_addr_reg, ar_addr_next;
   logic awready_reg, awready_next;
   logic wready_reg, wready_next;
   logic arready_reg, arready_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic rvalid_reg, rvalid_next;
   logic [1:0] rresp_reg, rresp_next;
   logic [7:0] rdata_reg, rdata_next;

   logic take_core, take_aw, take_ar, take;
   logic acc_we, axi_bad;
   logic [6:0] acc_offset, axi_idx;
   logic [7:0] acc_wdata, result;
   logic [8:0] acc_addr;
   bmd_kind_t acc_kind;
   logic mem_we;
   logic [8:0] mem_addr;
   logic [7:0] mem_rdata;

   // ----------------------------------------------------------------
   // Access selection and address formation
   // ----------------------------------------------------------------
   // Core wins over software in the same cycle; the instruction pipe still waits out an AXI access already taken
   always_comb
   begin
      take_core = (state_reg == BMD_ST_IDLE) && core_ready_reg && core_req;
      take_aw = (state_reg == BMD_ST_IDLE) && !core_req && aw_have_reg
                && w_have_reg && !bvalid_reg;
      take_ar = (state_reg == BMD_ST_IDLE) && !core_req && !take_aw
                && ar_have_reg && !rvalid_reg;
      take = take_core || take_aw || take_ar;
      axi_idx = take_aw ? {1'b0, aw_addr_reg[7:2]}
                        : {1'b0, ar_addr_reg[7:2]};
      axi_bad = !(axi_idx == BMD_IDX_WINDOW || axi_idx == BMD_IDX_STATUS
                  || axi_idx == BMD_IDX_POINTER
                  || axi_idx == BMD_IDX_INTERRUPT_CONTROL_REGISTER);
      acc_offset = take_core ? core_offset : axi_idx;
      acc_we = take_core ? core_we : (take_aw && w_lane_reg);
      acc_wdata = take_core ? core_wdata : w_data_reg;
      if (acc_offset == BMD_IDX_WINDOW)
      begin
         // indirect path shares the direct decode
         acc_addr = {status_reg[BMD_STATUS_IBANK_BIT], pointer_reg};
      end
      else
      begin
         acc_addr = {status_reg[BMD_STATUS_BANK_LSB+1:BMD_STATUS_BANK_LSB],
                     acc_offset};
      end
      // low seven bits index the 128-byte bank
      acc_kind = (!take_core && axi_bad) ? BMD_K_BAD : decode_kind(acc_addr);
      mem_we = take && acc_we && (acc_kind == BMD_K_RAM);
      mem_addr = ram_index(acc_addr);
   end

   // ----------------------------------------------------------------
   // RAM array
   // ----------------------------------------------------------------
   bmd_ram #(
      .WIDTH(BMD_DATA_W),
      .DEPTH(RAM_DEPTH),
      .AW(BMD_ADDR_W)
   ) u_ram (
      .aclk(aclk),
      .wr_en(mem_we),
      .addr(mem_addr),
      .wdata(acc_wdata),
      .rdata(mem_rdata)
   );

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      src_next = src_reg;
      kind_next = kind_reg;
      status_next = status_reg;
      pointer_next = pointer_reg;
      interrupt_control_register_next = interrupt_control_register_reg;
      core_ack_next = 1'b0;
      core_rdata_next = core_rdata_reg;
      periph_sel_next = 1'b0;
      periph_we_next = 1'b0;
      periph_addr_next = periph_addr_reg;
      periph_wdata_next = periph_wdata_reg;
      aw_have_next = aw_have_reg;
      w_have_next = w_have_reg;
      ar_have_next = ar_have_reg;
      aw_addr_next = aw_addr_reg;
      w_data_next = w_data_reg;
      w_lane_next = w_lane_reg;
      ar_addr_next = ar_addr_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      rvalid_next = rvalid_reg;
      rresp_next = rresp_reg;
      rdata_next = rdata_reg;
      result = BMD_SELF_READ;

      // AXI channel capture, either order
      if (s_axi_awvalid && awready_reg)
      begin
         aw_have_next = 1'b1;
         aw_addr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_reg)
      begin
         w_have_next = 1'b1;
         w_data_next = s_axi_wdata[7:0];
         w_lane_next = s_axi_wstrb[0];
      end
      if (s_axi_arvalid && arready_reg)
      begin
         ar_have_next = 1'b1;
         ar_addr_next = s_axi_araddr;
      end
      if (bvalid_reg && s_axi_bready)
         bvalid_next = 1'b0;
      if (rvalid_reg && s_axi_rready)
         rvalid_next = 1'b0;

      case (state_reg)
         BMD_ST_IDLE:
         begin
            if (take)
            begin
               state_next = BMD_ST_BUSY;
               kind_next = acc_kind;
               if (take_core)
                  src_next = BMD_SRC_CORE;
               else if (take_aw)
                  src_next = BMD_SRC_AXI_WR;
               else
                  src_next = BMD_SRC_AXI_RD;
               if (take_aw)
               begin
                  aw_have_next = 1'b0;
                  w_have_next = 1'b0;
               end
               if (take_ar)
                  ar_have_next = 1'b0;
               if (acc_we)
               begin
                  case (acc_kind)
                     BMD_K_STATUS: status_next = acc_wdata;
                     BMD_K_POINTER: pointer_next = acc_wdata;
                     BMD_K_INTERRUPT_CONTROL_REGISTER: interrupt_control_register_next = acc_wdata;
                     default: ;
                  endcase
               end
               if (acc_kind == BMD_K_PERIPH)
               begin
                  periph_sel_next = 1'b1;
                  periph_we_next = acc_we;
                  periph_addr_next = periph_index(acc_addr);
                  periph_wdata_next = acc_wdata;
               end
            end
         end
         BMD_ST_BUSY:
         begin
            state_next = BMD_ST_IDLE;
            case (kind_reg)
               BMD_K_RAM: result = mem_rdata;
               BMD_K_PERIPH: result = periph_rdata;
               BMD_K_STATUS: result = status_reg;
               BMD_K_POINTER: result = pointer_reg;
               BMD_K_INTERRUPT_CONTROL_REGISTER: result = interrupt_control_register_reg;
               default: result = BMD_SELF_READ;
            endcase
            case (src_reg)
               BMD_SRC_CORE:
               begin
                  core_ack_next = 1'b1;
                  core_rdata_next = result;
               end
               BMD_SRC_AXI_WR:
               begin
                  bvalid_next = 1'b1;
                  bresp_next = (kind_reg == BMD_K_BAD) ? BMD_RESP_SLVERR
                                                       : BMD_RESP_OKAY;
               end
               default:
               begin
                  rvalid_next = 1'b1;
                  rdata_next = result;
                  rresp_next = (kind_reg == BMD_K_BAD) ? BMD_RESP_SLVERR
                                                       : BMD_RESP_OKAY;
               end
            endcase
         end
         default: state_next = BMD_ST_IDLE;
      endcase

      // One write and one read held at a time; ready low while one is held or its response is pending
      awready_next = !aw_have_next && !bvalid_next;
      wready_next = !w_have_next && !bvalid_next;
      arready_next = !ar_have_next && !rvalid_next;
      core_ready_next = (state_next == BMD_ST_IDLE);
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_reg <= BMD_ST_IDLE;
         src_reg <= BMD_SRC_CORE;
         kind_reg <= BMD_K_SELF;
         status_reg <= BMD_STATUS_RST;
         pointer_reg <= BMD_POINTER_RST;
         interrupt_control_register_reg <= BMD_INTERRUPT_CONTROL_REGISTER_RST;
         core_ready_reg <= 1'b0;
         core_ack_reg <= 1'b0;
         core_rdata_reg <= '0;
         periph_sel_reg <= 1'b0;
         periph_we_reg <= 1'b0;
         periph_addr_reg <= '0;
         periph_wdata_reg <= '0;
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         ar_have_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg <= '0;
         w_lane_reg <= 1'b0;
         ar_addr_reg <= '0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         arready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= BMD_RESP_OKAY;
         rvalid_reg <= 1'b0;
         rresp_reg <= BMD_RESP_OKAY;
         rdata_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         src_reg <= src_next;
         kind_reg <= kind_next;
         status_reg <= status_next;
         pointer_reg <= pointer_next;
         interrupt_control_register_reg <= interrupt_control_register_next;
         core_ready_reg <= core_ready_next;
         core_ack_reg <= core_ack_next;
         core_rdata_reg <= core_rdata_next;
         periph_sel_reg <= periph_sel_next;
         periph_we_reg <= periph_we_next;
         periph_addr_reg <= periph_addr_next;
         periph_wdata_reg <= periph_wdata_next;
         aw_have_reg <= aw_have_next;
         w_have_reg <= w_have_next;
         ar_have_reg <= ar_have_next;
         aw_addr_reg <= aw_addr_next;
         w_data_reg <= w_data_next;
         w_lane_reg <= w_lane_next;
         ar_addr_reg <= ar_addr_next;
         awready_reg <= awready_next;
         wready_reg <= wready_next;
         arready_reg <= arready_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rresp_reg <= rresp_next;
         rdata_reg <= rdata_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign core_ready = core_ready_reg;
   assign core_ack = core_ack_reg;
   assign core_rdata = core_rdata_reg;
   assign periph_sel = periph_sel_reg;
   assign periph_we = periph_we_reg;
   assign periph_addr = periph_addr_reg;
   assign periph_wdata = periph_wdata_reg;
   assign machine_status = status_reg;
   assign indirect_pointer = pointer_reg;
   assign interrupt_control_register = interrupt_control_register_reg;
   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = {24'h000000, rdata_reg};

endmodule // bmd_decoder

// ### dv/bmd_periph_model.sv
// Peripheral register bank model facing the decoder
`timescale 1ns/1ps
module bmd_periph_model
   import bmd_pkg::*;
(
   input wire logic aclk,
   input wire logic periph_sel,
   input wire logic periph_we,
   input wire logic [BMD_ADDR_W-1:0] periph_addr,
   input wire logic [BMD_DATA_W-1:0] periph_wdata,
   output logic [BMD_DATA_W-1:0] periph_rdata
);
   logic [7:0] regs [0:511];
   logic [7:0] idle_pat = 8'h00;
   initial
   begin
      for (int i = 0; i < 512; i++)
         regs[i] = 8'h5A ^ i[7:0];
   end
   always @(posedge aclk)
   begin
      idle_pat <= idle_pat + 8'h3B;
      if (periph_sel && periph_we)
         regs[periph_addr] <= periph_wdata;
   end
   // Churns when idle so stale data never looks valid
   assign periph_rdata = periph_sel ? regs[periph_addr] : idle_pat;
endmodule // bmd_periph_model

// ### dv/bmd_decoder_properties.sv
// Port assertions for the banked data memory decoder
`timescale 1ns/1ps
module bmd_decoder_properties
   import bmd_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic core_req,
   input wire logic core_we,
   input wire logic [BMD_OFS_W-1:0] core_offset,
   input wire logic [BMD_DATA_W-1:0] core_wdata,
   input wire logic core_ready,
   input wire logic core_ack,
   input wire logic [BMD_DATA_W-1:0] core_rdata,
   input wire logic periph_sel,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_rvalid,
   input wire logic [BMD_DATA_W-1:0] machine_status,
   input wire logic [BMD_DATA_W-1:0] indirect_pointer,
   input wire logic [BMD_DATA_W-1:0] interrupt_control_register
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   logic take;
   logic wr;
   assign take = core_req && core_ready;
   assign wr = take && core_we;
   property p_ack_two;
      take |=> !core_ready ##1 (core_ack && core_ready);
   endproperty
   a_ack_two: assert property (p_ack_two)
      else $error("ack not two cycles after take");
   property p_ack_pulse;
      core_ack |=> !core_ack;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack longer than one cycle");
   property p_sel_ack;
      periph_sel |=> !periph_sel && (core_ack || s_axi_bvalid || s_axi_rvalid);
   endproperty
   a_sel_ack: assert property (p_sel_ack)
      else $error("peripheral strobe without ack");
   property p_ram_nosel;
      take && core_offset >= BMD_GPR_LOW_BASE |=> !periph_sel;
   endproperty
   a_ram_nosel: assert property (p_ram_nosel)
      else $error("ram offset reached peripherals");
   property p_interrupt_control_register;
      wr && core_offset == BMD_IDX_INTERRUPT_CONTROL_REGISTER
         |=> interrupt_control_register == $past(core_wdata);
   endproperty
   a_interrupt_control_register: assert property (p_interrupt_control_register)
      else $error("interrupt control not written");
   property p_status;
      wr && core_offset == BMD_IDX_STATUS
         |=> machine_status == $past(core_wdata);
   endproperty
   a_status: assert property (p_status)
      else $error("status not written");
   property p_pointer;
      wr && core_offset == BMD_IDX_POINTER
         |=> indirect_pointer == $past(core_wdata);
   endproperty
   a_pointer: assert property (p_pointer)
      else $error("pointer not written");
   property p_self_rd;
      take && !core_we && core_offset == BMD_IDX_WINDOW
         && indirect_pointer == 8'h00 |-> ##2 core_rdata == BMD_SELF_READ;
   endproperty
   a_self_rd: assert property (p_self_rd)
      else $error("self window read not zero");
   property p_self_wr;
      wr && core_offset == BMD_IDX_WINDOW && indirect_pointer == 8'h00
         |=> $stable(indirect_pointer) && $stable(machine_status);
   endproperty
   a_self_wr: assert property (p_self_wr)
      else $error("self window write stored");
   c_write: cover property (wr);
   c_periph: cover property (periph_sel);
   c_self: cover property (take && core_offset == BMD_IDX_WINDOW);
endmodule // bmd_decoder_properties
bind bmd_decoder bmd_decoder_properties i_props (.aclk, .aresetn,
   .core_req, .core_we, .core_offset, .core_wdata, .core_ready,
   .core_ack, .core_rdata, .periph_sel, .machine_status,
   .s_axi_bvalid, .s_axi_rvalid,
   .indirect_pointer, .interrupt_control_register);

// ### dv/bmd_decoder_bench.sv
// Self-checking bench for the banked data memory decoder
`timescale 1ns/1ps
module bmd_decoder_bench
   import bmd_pkg::*;
;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic core_req = 1'b0, core_we = 1'b0, core_ready, core_ack;
   logic [6:0] core_offset = 7'h00;
   logic [7:0] core_wdata = 8'h00, core_rdata, periph_wdata, periph_rdata;
   logic periph_sel, periph_we;
   logic [8:0] periph_addr;
   logic [7:0] machine_status, indirect_pointer, interrupt_control_register;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, ad;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [7:0] rd;
   int fails = 0;
   int checks_done = 0;
   int cycles = 0;
   always #12.5 aclk = ~aclk;
   bmd_decoder #(.RAM_DEPTH(512)) i_dut (.*);
   bmd_periph_model i_periph (.*);
   // ----------------------------------------
   // Access tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, g);
      checks_done++;
      if (g !== e)
      begin
         $display("mismatch %s expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask
   task automatic cacc(input logic we, input logic [6:0] o,
                       input logic [7:0] d);
      core_req <= 1'b1;
      core_we <= we;
      core_offset <= o;
      core_wdata <= d;
      do @(posedge aclk); while (core_ready !== 1'b1);
      core_req <= 1'b0;
      do @(posedge aclk); while (core_ack !== 1'b1);
      rd = core_rdata;
   endtask
   task automatic sel(input logic indirect_bank_bit, input logic [1:0] b);
      cacc(1'b1, BMD_IDX_STATUS, {indirect_bank_bit, b, 5'h00});
   endtask
   task automatic chkrd(input logic [6:0] o, input logic [7:0] e);
      cacc(1'b0, o, 8'h00);
      chk("core_rdata", {24'h0, e}, {24'h0, rd});
   endtask
   task automatic awr(input logic [7:0] a, d, input logic [3:0] st);
      logic ah;
      logic wh;
      ah = 1'b0;
      wh = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ah && wh))
      begin
         @(posedge aclk);
         ah = ah || s_axi_awready;
         wh = wh || s_axi_wready;
         s_axi_awvalid <= !ah;
         s_axi_wvalid <= !wh;
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
   endtask
   task automatic ard(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      ad = s_axi_rdata;
      rsp = s_axi_rresp;
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Whole run is a few hundred cycles
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         give_verdict();
      end
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial
   begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 3; i < 12; i += 4)
      begin
         ard(8'(i * 4) + 8'h00);
         chk("s_axi_rdata", 32'h0, ad);
      end
      ard(8'h14);
      chk("s_axi_rresp", {30'h0, BMD_RESP_SLVERR}, {30'h0, rsp});
      for (int b = 0; b < 4; b++)
      begin
         sel(1'b0, b[1:0]);
         cacc(1'b1, 7'h20, 8'h10 + 8'(b));
         cacc(1'b1, 7'h6F, 8'hE0 + 8'(b));
      end
      cacc(1'b1, 7'h7F, 8'hC3);
      for (int b = 0; b < 4; b++)
      begin
         sel(1'b0, b[1:0]);
         chkrd(7'h20, 8'h10 + 8'(b));
         chkrd(7'h6F, 8'hE0 + 8'(b));
         chkrd(7'h7F, 8'hC3);
         chkrd(BMD_IDX_STATUS, {1'b0, b[1:0], 5'h00});
         chk("machine_status", b * 32, machine_status);
         cacc(1'b1, BMD_IDX_INTERRUPT_CONTROL_REGISTER, 8'h80 + 8'(b));
         chk("interrupt_control_register", 8'h80 + b, interrupt_control_register);
      end
      chkrd(7'h05, 8'h00);
      sel(1'b0, 2'b00);
      cacc(1'b1, BMD_IDX_POINTER, 8'hA0);
      chkrd(BMD_IDX_WINDOW, 8'h11);
      cacc(1'b1, BMD_IDX_WINDOW, 8'h5E);
      sel(1'b0, 2'b01);
      chkrd(7'h20, 8'h5E);
      sel(1'b1, 2'b00);
      chkrd(BMD_IDX_WINDOW, 8'h13);
      sel(1'b0, 2'b00);
      cacc(1'b1, BMD_IDX_POINTER, 8'h00);
      cacc(1'b1, BMD_IDX_WINDOW, 8'hFF);
      chk("indirect_pointer", 8'h00, indirect_pointer);
      chkrd(BMD_IDX_WINDOW, BMD_SELF_READ);
      cacc(1'b1, BMD_OFS_ALL_B, 8'h3C);
      chk("periph_addr", 9'h00A, periph_addr);
      sel(1'b0, 2'b11);
      chkrd(BMD_OFS_ALL_B, 8'h3C);
      cacc(1'b1, BMD_OFS_PAIR_B, 8'h66);
      sel(1'b0, 2'b01);
      chkrd(BMD_OFS_PAIR_B, 8'h66);
      awr(8'h10, 8'h21, 4'hF);
      chk("indirect_pointer", 8'h21, indirect_pointer);
      awr(8'h00, 8'h77, 4'hF);
      awr(8'h00, 8'h99, 4'h0);
      sel(1'b0, 2'b00);
      chkrd(7'h21, 8'h77);
      ard(8'h00);
      chk("s_axi_rdata", 32'h77, ad);
      awr(8'h18, 8'h01, 4'hF);
      chk("s_axi_bresp", {30'h0, BMD_RESP_SLVERR}, {30'h0, rsp});
      give_verdict();
   end
endmodule // bmd_decoder_bench
